// ===== logic/ccss_defines.svh
// constants for the cpu clock source switch: register offset, bit positions, reset value
// assumes a 4-bit data bus with an 8-bit i/o address from the cpu core
`ifndef CCSS_DEFINES_SVH
`define CCSS_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define CCSS_CTRL_ADDR 8'hfe
`define CCSS_CTRL_RESET 4'h0
`define CCSS_BIT_SELECT 2
`define CCSS_BIT_FAST_EN 1
`define CCSS_BIT_DIR 0

// ****************************************
// timing
// ****************************************
`define CCSS_FAST_START_MS 5
`define CCSS_CLK_MHZ 100

`endif

// ===== logic/ccss_pkg.sv
// types for the cpu clock source switch
// assumes the defines header is included by the module that imports this
package ccss_pkg;

   // ****************************************
   // switch state machine
   // ****************************************
   typedef enum logic [1:0] {
      CCSS_SLOW = 2'b00, // running on slow oscillator
      CCSS_TO_FAST = 2'b01, // waiting for clean edges before fast
      CCSS_FAST = 2'b10, // running on fast oscillator
      CCSS_TO_SLOW = 2'b11 // waiting for clean edges before slow
   } ccss_state_t;

   // ****************************************
   // bus request carrier
   // ****************************************
   typedef struct packed {
      logic rd; // read strobe
      logic wr; // write strobe
      logic [7:0] addr; // i/o address
      logic [3:0] wdata; // write data
   } ccss_bus_t;

   // ****************************************
   // whole module state
   // ****************************************
   typedef struct packed {
      logic select; // cpu clock select bit
      logic fast_en; // fast oscillator enable bit
      logic dir; // port1 direction bit
      logic [3:0] rdata; // read data register
      ccss_state_t st; // switch state
      logic use_fast; // current cpu clock source
      logic [1:0] slow_sync; // synchroniser of slow clock level
      logic [1:0] fast_sync; // synchroniser of fast clock level
      logic slow_prev; // previous synced slow level
      logic fast_prev; // previous synced fast level
   } ccss_state_s_t;

endpackage

// ===== logic/ccss_clock_switch.sv
// control register and clock source switch logic for the cpu clock
// assumes the cpu core issues one-cycle read/write strobes on core_clk,
// and that slow/fast oscillator levels arrive asynchronously as pins;
// the cpu clock mux itself sits outside and follows cpu_clock_use_fast
`timescale 1ns/1ns
`include "ccss_defines.svh"

module ccss_clock_switch #(
   parameter bit HAS_FAST_OSC = 1'b1 // variant carries the fast oscillator
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire ccss_pkg::ccss_bus_t bus_req,
   output logic [3:0] bus_rdata,
   input wire logic slow_oscillator,
   input wire logic fast_oscillator,
   output logic fast_oscillator_enable,
   output logic cpu_clock_use_fast,
   output logic port1_direction,
   output logic cpu_clock_select
);
   import ccss_pkg::*;

   // ****************************************
   // reset image of the whole state
   // ****************************************
   // edge history starts high, but the synchronisers start low, so a pin
   // already high at release still shows a rising boundary two cycles later
   localparam ccss_state_s_t S_RESET = '{
      select: 1'b0, // slow oscillator chosen
      fast_en: 1'b0, // fast oscillator stopped
      dir: 1'b0, // port1 pins are inputs
      rdata: 4'h0, // no read pending
      st: CCSS_SLOW, // machine idles on slow
      use_fast: 1'b0, // cpu runs from slow
      slow_sync: 2'h0, // synchroniser cleared
      fast_sync: 2'h0, // synchroniser cleared
      slow_prev: 1'b1, // set high, masks nothing: sync starts low
      fast_prev: 1'b1 // set high, masks nothing: sync starts low
   };

   // ****************************************
   // state registers
   // ****************************************
   ccss_state_s_t s_r; // registered state
   ccss_state_s_t s_nxt; // next state
   logic slow_rise; // clean slow clock rising boundary
   logic fast_rise; // clean fast clock rising boundary
   logic wr_hit; // write to control register
   logic rd_hit; // read of control register

   // ****************************************
   // register address decode
   // ****************************************
   // only the one address is decoded; every other address reads zero
   assign wr_hit = bus_req.wr && (bus_req.addr == `CCSS_CTRL_ADDR);
   assign rd_hit = bus_req.rd && (bus_req.addr == `CCSS_CTRL_ADDR);

   // ****************************************
   // oscillator boundary detection
   // ****************************************
   // edges judged from the second stage only, never the first flop
   assign slow_rise = s_r.slow_sync[1] && !s_r.slow_prev;
   assign fast_rise = s_r.fast_sync[1] && !s_r.fast_prev;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      // every field holds unless overridden below
      // synchronisers and edge history
      s_nxt.slow_sync = {s_r.slow_sync[0], slow_oscillator};
      s_nxt.fast_sync = {s_r.fast_sync[0], fast_oscillator};
      s_nxt.slow_prev = s_r.slow_sync[1];
      s_nxt.fast_prev = s_r.fast_sync[1];
      // register writes
      if (wr_hit) begin
         s_nxt.select = bus_req.wdata[`CCSS_BIT_SELECT];
         s_nxt.fast_en = bus_req.wdata[`CCSS_BIT_FAST_EN];
         s_nxt.dir = bus_req.wdata[`CCSS_BIT_DIR];
      end
      // read returns stored bits, bit 3 is always zero
      // a write and a read in one cycle return the old value
      if (rd_hit) begin
         s_nxt.rdata = {1'b0, s_r.select, s_r.fast_en, s_r.dir};
      end else begin
         s_nxt.rdata = 4'h0;
      end
      // switch sequencing: wait for a boundary of the clock being left,
      // then of the clock being taken, so no short pulse reaches the cpu
      case (s_r.st)
         CCSS_SLOW: begin
            // fast select ignored on variants without the oscillator
            if (s_r.select && HAS_FAST_OSC && slow_rise) begin
               s_nxt.st = CCSS_TO_FAST;
            end
         end
         CCSS_TO_FAST: begin
            // deselected before the fast edge: abandon, still on slow
            if (!s_r.select) begin
               s_nxt.st = CCSS_SLOW;
            end else if (fast_rise) begin
               s_nxt.use_fast = 1'b1;
               s_nxt.st = CCSS_FAST;
            end
         end
         CCSS_FAST: begin
            // limitation: losing the enable while on fast is software's fault
            if (!s_r.select && fast_rise) begin
               s_nxt.st = CCSS_TO_SLOW;
            end
         end
         CCSS_TO_SLOW: begin
            // fast boundary already seen, cpu still on fast; take slow at its edge
            if (slow_rise) begin
               s_nxt.use_fast = 1'b0;
               s_nxt.st = CCSS_SLOW;
            end
         end
         default: begin
            // unreachable codes recover to the slow clock
            s_nxt.st = CCSS_SLOW;
            s_nxt.use_fast = 1'b0;
         end
      endcase
   end

   // ****************************************
   // state register with async reset
   // ****************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // constants only: no pin level is sampled during reset
         s_r <= S_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // outputs straight from flops, no logic after the register
   assign bus_rdata = s_r.rdata;
   assign fast_oscillator_enable = s_r.fast_en;
   assign cpu_clock_use_fast = s_r.use_fast;
   assign port1_direction = s_r.dir;
   assign cpu_clock_select = s_r.select;

   // ****************************************
   // checks
   // ****************************************
   // bit 3 has no storage and the select bit reads back
   chk_read_bit3_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      rd_hit |=> (bus_rdata[3] == 1'b0) && (bus_rdata[2] == $past(s_r.select)))
      else $error("control read bad");
   // written enable and direction appear one cycle later
   chk_write_stores: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_hit |=> (port1_direction == $past(bus_req.wdata[0]))
         && (fast_oscillator_enable == $past(bus_req.wdata[1])))
      else $error("control write lost");
   // variants lacking the oscillator never leave the slow clock
   chk_no_fast_variant: assert property (@(posedge core_clk) disable iff (!nrst)
      !HAS_FAST_OSC |-> !cpu_clock_use_fast)
      else $error("fast clock on variant lacking it");
   // fast taken only one cycle after a fast boundary, from transit
   chk_fast_on_boundary: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cpu_clock_use_fast) |-> $past(fast_rise) && $past(s_r.st == CCSS_TO_FAST))
      else $error("fast switch off boundary");
   // slow taken only one cycle after a slow boundary
   chk_slow_on_boundary: assert property (@(posedge core_clk) disable iff (!nrst)
      $fell(cpu_clock_use_fast) |-> $past(slow_rise))
      else $error("slow switch off boundary");
   // a deselect on fast leaves at the next fast boundary
   chk_select_drives: assert property (@(posedge core_clk) disable iff (!nrst)
      cpu_clock_use_fast && !cpu_clock_select |-> ##[0:1] s_r.st != CCSS_FAST || !fast_rise)
      else $error("deselect not followed");
   // direction holds between writes
   chk_dir_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      !wr_hit |=> $stable(port1_direction))
      else $error("direction changed without write");
   // read data is a one-cycle pulse, zero otherwise
   chk_idle_read_zero: assert property (@(posedge core_clk) disable iff (!nrst)
      !rd_hit |=> bus_rdata == 4'h0)
      else $error("read data without read");

   // ****************************************
   // checks on reset, decode and switch order
   // ****************************************
   // a write taken at the release edge must not hide a stuck output
   chk_reset_clears: assert property (@(posedge core_clk)
      $rose(nrst) |-> (fast_oscillator_enable == 1'b0) && (cpu_clock_select == 1'b0)
         && (port1_direction == 1'b0) && (cpu_clock_use_fast == 1'b0))
      else $error("outputs not cleared by reset");
   // a near miss on the address must leave every bit alone
   chk_unmapped_ignored: assert property (@(posedge core_clk) disable iff (!nrst)
      bus_req.wr && (bus_req.addr != `CCSS_CTRL_ADDR)
         |=> $stable(cpu_clock_select) && $stable(fast_oscillator_enable)
         && $stable(port1_direction))
      else $error("unmapped write landed");
   // low two read bits mirror the stored enable and direction
   chk_read_fields: assert property (@(posedge core_clk) disable iff (!nrst)
      rd_hit |=> bus_rdata[1:0] == $past({fast_oscillator_enable, port1_direction}))
      else $error("read fields wrong");
   // select is stored even where it has no effect
   chk_select_stores: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_hit |=> cpu_clock_select == $past(bus_req.wdata[`CCSS_BIT_SELECT]))
      else $error("select write lost");
   // enable and select only move on a decoded write
   chk_enable_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      !wr_hit |=> $stable(fast_oscillator_enable) && $stable(cpu_clock_select))
      else $error("enable or select moved without write");
   // the fast clock is only taken while it is selected
   chk_fast_needs_select: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cpu_clock_use_fast) |-> $past(cpu_clock_select))
      else $error("fast clock taken without select");
   // the source only moves out of a transit state
   chk_source_in_transit: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(cpu_clock_use_fast)
         |-> $past(s_r.st == CCSS_TO_FAST) || $past(s_r.st == CCSS_TO_SLOW))
      else $error("source moved outside transit");
   // each source holds at least two cycles, so no runt selection
   chk_fast_holds: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cpu_clock_use_fast) |=> cpu_clock_use_fast)
      else $error("fast clock dropped at once");
   chk_slow_holds: assert property (@(posedge core_clk) disable iff (!nrst)
      $fell(cpu_clock_use_fast) |=> !cpu_clock_use_fast)
      else $error("slow clock dropped at once");

endmodule // ccss_clock_switch

// ===== test/ccss_cpu_model.sv
// cpu core stand-in: register reads and writes on the i/o bus
// assumes the bench calls its tasks and owns core_clk
`timescale 1ns/1ns
module ccss_cpu_model #(
   parameter int SETTLE_CYC = 40 // shortened oscillator start wait
) (
   input wire logic core_clk,
   output ccss_pkg::ccss_bus_t bus_req,
   input wire logic [3:0] bus_rdata
);
   import ccss_pkg::*;
   // ****************************************
   // bus cycles, launched on the falling edge
   // ****************************************
   initial bus_req = '0;
   // released address and data are inverted so stale values never match
   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      @(negedge core_clk);
      bus_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge core_clk);
      bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [3:0] d);
      @(negedge core_clk);
      bus_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
      @(negedge core_clk);
      bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 4'hf};
      d = bus_rdata;
   endtask
   // ****************************************
   // clock switch sequences
   // ****************************************
   // start oscillator, let it settle, then select it
   task automatic go_fast(input logic d);
      wr(8'hfe, {3'b001, d});
      repeat (SETTLE_CYC) @(negedge core_clk);
      wr(8'hfe, {3'b011, d});
   endtask
   // deselect first, stop oscillator only in a later write
   task automatic go_slow(input logic d);
      wr(8'hfe, {3'b001, d});
      repeat (SETTLE_CYC) @(negedge core_clk);
      wr(8'hfe, {3'b000, d});
   endtask
endmodule // ccss_cpu_model

// ===== test/cpu_clock_source_switch_tb.sv
// self-checking bench for the cpu clock source switch
// assumes the design under logic/ and the cpu model under test/
`timescale 1ns/1ns
module cpu_clock_source_switch_tb;
   import ccss_pkg::*;
   typedef struct {logic [3:0] w; logic [3:0] r;} ccss_row_t;
   logic core_clk = 1'b0, nrst = 1'b0, slow_osc = 1'b0, fast_osc = 1'b0;
   ccss_bus_t bus_req;
   logic [3:0] rdata, got;
   logic fen, use_fast, dir, sel, use_fast_v;
   int bad_count = 0, num_checks = 0, cyc = 0;
   ccss_row_t rows [5] = '{'{4'h1, 4'h1}, '{4'h2, 4'h2}, '{4'h8, 4'h0},
      '{4'hb, 4'h3}, '{4'h0, 4'h0}};
   // ****************************************
   // clocks; fast oscillator only runs while enabled
   // ****************************************
   initial forever #5 core_clk = ~core_clk;
   initial forever #100 slow_osc = ~slow_osc;
   initial forever #30 fast_osc = fen ? ~fast_osc : 1'b0;
   ccss_clock_switch u_dut (.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata(rdata), .slow_oscillator(slow_osc), .fast_oscillator(fast_osc),
      .fast_oscillator_enable(fen), .cpu_clock_use_fast(use_fast),
      .port1_direction(dir), .cpu_clock_select(sel));
   // variant without fast oscillator sees the same bus, but its
   // software keeps the missing oscillator's enable at zero
   ccss_bus_t var_req;
   assign var_req = '{rd: bus_req.rd, wr: bus_req.wr, addr: bus_req.addr,
      wdata: bus_req.wdata & 4'hd};
   ccss_clock_switch #(.HAS_FAST_OSC(1'b0)) u_var (.core_clk(core_clk), .nrst(nrst),
      .bus_req(var_req), .bus_rdata(), .slow_oscillator(slow_osc),
      .fast_oscillator(fast_osc), .fast_oscillator_enable(),
      .cpu_clock_use_fast(use_fast_v), .port1_direction(), .cpu_clock_select());
   ccss_cpu_model u_cpu (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(rdata));
   // ****************************************
   // compare and closing
   // ****************************************
   task automatic chk(input logic [3:0] g, input logic [3:0] e, input string m);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard, well above the run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         end_sim();
      end
   end
   // bounded wait for the switch, both clocks must toggle meanwhile
   task automatic wait_src(input logic v);
      int n;
      n = 0;
      while (use_fast !== v && n < 80) begin
         @(negedge core_clk);
         n++;
      end
      chk({3'b000, use_fast}, {3'b000, v}, "clock source");
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (6) @(negedge core_clk);
      nrst = 1'b1;
      chk({sel, fen, dir, use_fast}, 4'h0, "reset outputs");
      u_cpu.rd(8'hfe, got);
      chk(got, 4'h0, "reset read");
      foreach (rows[i]) begin
         u_cpu.wr(8'hfe, rows[i].w);
         u_cpu.rd(8'hfe, got);
         chk(got, rows[i].r, "readback");
         chk({1'b0, sel, fen, dir}, rows[i].r, "outputs");
      end
      u_cpu.wr(8'hef, 4'h7);
      u_cpu.rd(8'hef, got);
      chk(got, 4'h0, "unmapped read");
      chk({1'b0, sel, fen, dir}, 4'h0, "unmapped write");
      u_cpu.go_fast(1'b1);
      wait_src(1'b1);
      u_cpu.rd(8'hfe, got);
      chk(got, 4'h7, "fast readback");
      chk({3'b000, use_fast_v}, 4'h0, "variant source");
      u_cpu.go_slow(1'b1);
      chk({1'b0, sel, fen, use_fast}, 4'h0, "back to slow");
      // select dropped right after it was set: the switch is abandoned
      // or undone, and the slow clock must be back in bounded time
      u_cpu.go_fast(1'b0);
      u_cpu.wr(8'hfe, 4'h2);
      repeat (40) @(negedge core_clk);
      chk({1'b0, sel, fen, use_fast}, 4'h2, "abandoned switch");
      u_cpu.go_fast(1'b0);
      wait_src(1'b1);
      nrst = 1'b0;
      @(negedge core_clk);
      chk({sel, fen, dir, use_fast}, 4'h0, "mid-run reset");
      nrst = 1'b1;
      u_cpu.wr(8'hfe, 4'h1);
      u_cpu.rd(8'hfe, got);
      chk(got, 4'h1, "after mid-run reset");
      end_sim();
   end
endmodule // cpu_clock_source_switch_tb
